/* File: design/ssm_motor_mod.sv */
// motor output modulator: pulse density or two-line pwm
// assumes a signed drive level held in a register of the same clock
`timescale 1ns/100ps
module ssm_motor_mod import ssm_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_drive,
  input  wire logic         i_pwm_mode,
  output logic              o_motor_drive_primary,
  output logic              o_motor_drive_secondary
);
  typedef struct packed {
    logic [W-1:0] acc;
    logic [W-1:0] cnt;
    logic         pri;
    logic         sec;
  } ssm_mod_s;
  ssm_mod_s st_reg, st_next;
  logic [W:0]   sum;
  logic [W-1:0] mag;
  logic         neg;

  always_comb begin
    st_next = st_reg;
    neg     = i_drive[W-1];
    mag     = neg ? W'(-i_drive) : i_drive;
    // offset binary so that zero drive gives half duty
    sum     = {1'b0, st_reg.acc} + {1'b0, ~i_drive[W-1], i_drive[W-2:0]};
    st_next.acc = sum[W-1:0];
    st_next.cnt = st_reg.cnt + W'(1);
    if (i_pwm_mode) begin
      // accelerate on primary, brake on secondary
      st_next.pri = !neg && (st_reg.cnt < mag);
      st_next.sec = neg && (st_reg.cnt < mag);
    end else begin
      st_next.pri = sum[W];
      st_next.sec = !sum[W];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_motor_drive_primary   = st_reg.pri;
  assign o_motor_drive_secondary = st_reg.sec;
endmodule

/* File: design/ssm_pkg.sv */
// constants and types shared by the spindle servo mode controller
// assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus
package ssm_pkg;
  // register byte addresses
  localparam logic [7:0] A_MODE    = 8'h00;
  localparam logic [7:0] A_OUTCFG  = 8'h04;
  localparam logic [7:0] A_LOOP    = 8'h08;
  localparam logic [7:0] A_STATUS  = 8'h0C;
  localparam logic [7:0] A_IRQ_ST  = 8'h10;
  localparam logic [7:0] A_IRQ_EN  = 8'h14;
  localparam logic [7:0] A_IRQ_CLR = 8'h18;
  localparam logic [7:0] A_DRIVE   = 8'h1C;
  // field positions
  localparam int F_AWU   = 3;
  localparam int F_PWM   = 2;
  localparam int F_BRAKE = 3;
  localparam int F_OSPD  = 4;
  localparam int F_F4    = 3;
  localparam int F_F3    = 5;
  localparam int F_HALT  = 3;
  localparam int F_SAT   = 4;
  localparam int F_PLAYI = 5;
  // irq bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_JUMP = 0;
  localparam int IRQ_HALT = 1;
  localparam int IRQ_OVF  = 2;
  // axi responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // speed thresholds in percent of nominal
  localparam logic [7:0] PCT_JUMP = 8'h4B;
  localparam logic [7:0] PCT_BRK12 = 8'h0C;
  localparam logic [7:0] PCT_BRK6  = 8'h06;
  // drive levels: full, 75, 50 and 37 percent of full scale
  localparam logic [7:0] DRV_MAX = 8'h7F;
  localparam logic [7:0] LIM_TBL [4] = '{8'h7F, 8'h5F, 8'h3F, 8'h2F};
  // loop gains 3.2 .. 32 in 4 fractional bits, ascending codes
  localparam logic [9:0] GAIN_TBL [8] = '{10'h033, 10'h040, 10'h066, 10'h080,
                                          10'h0CD, 10'h100, 10'h19A, 10'h200};
  localparam int GAIN_FRAC = 4;
  localparam int INT_FRAC  = 4;
  localparam int INT_SHIFT_BASE = 3;
  localparam int LP_SHIFT_BASE  = 2;
  // servo sample period at n = 1
  localparam int CLK_MHZ        = 40;
  localparam int SERVO_TICK_US  = 100;
  localparam int SERVO_TICK_CYC = SERVO_TICK_US * CLK_MHZ;
  typedef enum logic [2:0] {
    M_START1 = 3'b000, M_START2 = 3'b001, M_JUMP  = 3'b010, M_JUMP1 = 3'b011,
    M_PLAY   = 3'b100, M_STOP1  = 3'b101, M_STOP2 = 3'b110, M_OFF   = 3'b111
  } ssm_mode_e;
endpackage

/* File: design/ssm_servo_top.sv */
// spindle motor servo mode controller with AXI4-Lite registers
// assumes speed and fifo error come from logic on i_clk; overflow is a pin
// Operation
// - one register picks mode and anti-windup
// - anti-windup holds integrator while drive saturates
// - start/stop drive fixed level, limited magnitude
// - limits are full, 75, 50, 37 percent
// - eight loop gains from 3.2 to 32
// - crossovers scale with overspeed, gain does not
// - play overflow resets fifo half, conceals
// - start 1: push, pll reset, no speed
// - start 2 goes to jump at 75 percent
// - jump: servo on, fifo held, integrator held
// - data mode keeps serial data unmuted in jump
// - jump 1 forces integrator to zero
// - play entry resets fifo then releases, unmutes
// - stop 1 brakes open loop, no decisions
// - stop 2 halts at 12/6 percent, off
// - density output, half duty idle, inverse pair
// - pwm: accelerate on primary, brake secondary
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module ssm_servo_top import ssm_pkg::*; #(
  parameter int DW = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic [7:0]    i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  input  wire logic [7:0]    i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  input  wire logic [7:0]    i_speed_pct,
  input  wire logic [DW-1:0] i_fifo_err,
  input  wire logic          i_fifo_overflow,
  input  wire logic          i_cdrom_mode,
  output logic               o_pll_reset,
  output logic               o_speed_valid,
  output logic               o_fifo_reset_half,
  output logic               o_conceal,
  output logic               o_audio_mute,
  output logic               o_serial_mute,
  output logic               o_spindle_halted_flag,
  output logic               o_motor_drive_primary,
  output logic               o_motor_drive_secondary,
  output logic               o_irq
);
  typedef struct packed {
    ssm_mode_e          mode;
    logic               awu;
    logic [1:0]         plim;
    logic               pwm;
    logic               brake6;
    logic [1:0]         ospd;
    logic [2:0]         gain;
    logic [1:0]         f4;
    logic [1:0]         f3;
    logic               halted;
    logic               play_init;
    logic               conceal;
    logic [IRQ_W-1:0]   irq_st;
    logic [IRQ_W-1:0]   irq_en;
    logic               ovf_s1;
    logic               ovf_s2;
    logic               ovf_d;
    logic [12:0]        tick_cnt;
    logic signed [15:0] integ;
    logic signed [7:0]  pfilt;
    logic signed [7:0]  drive;
    logic               sat;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } ssm_state_s;

  ssm_state_s         st_reg, st_next;
  logic [1:0]         rst_sync;
  logic               rst_n;
  logic               wr_go, rd_go, wr_mode, ovf_rise, tick, closed, freeze;
  logic [7:0]         lim, brk_pct;
  logic [12:0]        tick_last;
  logic signed [7:0]  err;
  logic signed [19:0] prop, sum;
  logic signed [15:0] integ_step;
  logic signed [8:0]  lp_diff;
  logic [IRQ_W-1:0]   irq_set;

  function automatic logic [7:0] lim_of(input logic [1:0] code);
    lim_of = LIM_TBL[code];
  endfunction

  function automatic logic [9:0] gain_of(input logic [2:0] code);
    gain_of = GAIN_TBL[code];
  endfunction

  function automatic logic [31:0] zx8(input logic [7:0] v);
    zx8 = {24'h000000, v};
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign wr_go     = i_awvalid && i_wvalid && !st_reg.bvalid;
  assign rd_go     = i_arvalid && !st_reg.rvalid;
  assign wr_mode   = wr_go && i_wstrb[0] && (i_awaddr == A_MODE);
  assign ovf_rise  = st_reg.ovf_s2 && !st_reg.ovf_d;
  // sample rate scales with n, so crossovers do too
  assign tick_last = 13'(SERVO_TICK_CYC >> st_reg.ospd) - 13'h0001;
  assign tick      = (st_reg.tick_cnt >= tick_last);
  assign lim       = lim_of(st_reg.plim);
  assign brk_pct   = st_reg.brake6 ? PCT_BRK6 : PCT_BRK12;
  assign closed    = st_reg.mode inside {M_JUMP, M_JUMP1, M_PLAY};
  assign err       = i_fifo_err;
  assign prop      = (20'($signed(st_reg.pfilt)) * 20'($signed({1'b0, gain_of(st_reg.gain)})))
                     >>> GAIN_FRAC;
  assign sum       = prop + 20'(st_reg.integ >>> INT_FRAC);
  assign lp_diff   = 9'(err) - 9'(st_reg.pfilt);
  assign integ_step = 16'(err) >>> (INT_SHIFT_BASE - int'(st_reg.f4));
  // hold while the output is clipped with anti-windup on, and in jump
  assign freeze    = (st_reg.awu && st_reg.sat) || st_reg.mode == M_JUMP;

  always_comb begin
    st_next = st_reg;
    irq_set = '0;
    st_next.ovf_s1  = i_fifo_overflow;
    st_next.ovf_s2  = st_reg.ovf_s1;
    st_next.ovf_d   = st_reg.ovf_s2;
    st_next.tick_cnt = tick ? 13'h0000 : st_reg.tick_cnt + 13'h0001;
    st_next.play_init = 1'b0;
    st_next.conceal = 1'b0;

    // autonomous switch to jump at 75 percent
    if (st_reg.mode == M_START2 && i_speed_pct >= PCT_JUMP) begin
      st_next.mode = M_JUMP;
      irq_set[IRQ_JUMP] = 1'b1;
    end
    if (st_reg.mode == M_STOP2 && i_speed_pct <= brk_pct) begin
      st_next.mode   = M_OFF;
      st_next.halted = 1'b1;
      irq_set[IRQ_HALT] = 1'b1;
    end
    // overflow in play: conceal, fifo back to half
    if (st_reg.mode == M_PLAY && ovf_rise) begin
      st_next.conceal = 1'b1;
      irq_set[IRQ_OVF] = 1'b1;
    end

    // closed-loop servo update
    if (tick) begin
      st_next.pfilt = 8'(9'($signed(st_reg.pfilt)) + (lp_diff >>> (LP_SHIFT_BASE -
                        int'(st_reg.f3 == 2'h3 ? 2'h2 : st_reg.f3))));
      if (closed && !freeze) begin
        st_next.integ = st_reg.integ + integ_step;
      end
    end
    // jump 1 keeps integrator at zero
    if (st_reg.mode == M_JUMP1 || st_reg.mode == M_OFF) begin
      st_next.integ = '0;
    end

    st_next.sat = 1'b0;
    case (st_reg.mode)
      // open loop positive push; start 2 still switches to jump at 75 percent
      M_START1, M_START2: st_next.drive = $signed(lim);
      M_STOP1, M_STOP2:   st_next.drive = -$signed(lim);
      M_JUMP, M_JUMP1, M_PLAY: begin
        if (sum > $signed(20'(DRV_MAX))) begin
          st_next.drive = $signed(DRV_MAX);
          st_next.sat   = 1'b1;
        end else if (sum < -$signed(20'(DRV_MAX))) begin
          st_next.drive = -$signed(DRV_MAX);
          st_next.sat   = 1'b1;
        end else begin
          st_next.drive = 8'(sum);
        end
      end
      M_OFF:   st_next.drive = '0;
      default: st_next.drive = '0;
    endcase

    // write channel, address and data taken together
    if (wr_go) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OK;
      if (i_wstrb[0]) begin
        case (i_awaddr)
          A_MODE: begin
            // mode and anti-windup from one register
            st_next.mode   = ssm_mode_e'(i_wdata[2:0]);
            st_next.awu    = i_wdata[F_AWU];
            st_next.halted = irq_set[IRQ_HALT];
            st_next.play_init = (ssm_mode_e'(i_wdata[2:0]) == M_PLAY) &&
                                (st_reg.mode != M_PLAY);
          end
          A_OUTCFG: begin
            st_next.plim   = i_wdata[1:0];
            st_next.pwm    = i_wdata[F_PWM];
            st_next.brake6 = i_wdata[F_BRAKE];
            st_next.ospd   = i_wdata[F_OSPD +: 2];
          end
          A_LOOP: begin
            st_next.gain = i_wdata[2:0];
            st_next.f4   = i_wdata[F_F4 +: 2];
            st_next.f3   = i_wdata[F_F3 +: 2];
          end
          A_IRQ_EN:  st_next.irq_en = i_wdata[IRQ_W-1:0];
          A_IRQ_CLR: st_next.irq_st = st_reg.irq_st & ~i_wdata[IRQ_W-1:0];
          A_STATUS, A_IRQ_ST, A_DRIVE: st_next.bresp = RESP_OK;
          default: st_next.bresp = RESP_ERR;
        endcase
      end
    end else if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end
    // set wins over clear
    st_next.irq_st = st_next.irq_st | irq_set;

    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OK;
      case (i_araddr)
        A_MODE:   st_next.rdata = zx8({4'h0, st_reg.awu, st_reg.mode});
        A_OUTCFG: st_next.rdata = zx8({2'h0, st_reg.ospd, st_reg.brake6, st_reg.pwm,
                                       st_reg.plim});
        A_LOOP:   st_next.rdata = zx8({1'b0, st_reg.f3, st_reg.f4, st_reg.gain});
        A_STATUS: st_next.rdata = zx8({2'h0, st_reg.play_init, st_reg.sat,
                                       st_reg.halted, st_reg.mode});
        A_IRQ_ST: st_next.rdata = zx8({5'h00, st_reg.irq_st});
        A_IRQ_EN: st_next.rdata = zx8({5'h00, st_reg.irq_en});
        A_IRQ_CLR: st_next.rdata = '0;
        A_DRIVE:  st_next.rdata = zx8(st_reg.drive);
        default: begin
          st_next.rdata = '0;
          st_next.rresp = RESP_ERR;
        end
      endcase
    end else if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= '0;
      st_reg.mode <= M_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  ssm_motor_mod #(.W(DW)) u_mod (
    .i_clk                   (i_clk),
    .i_rst_n                 (rst_n),
    .i_drive                 (st_reg.drive),
    .i_pwm_mode              (st_reg.pwm),
    .o_motor_drive_primary   (o_motor_drive_primary),
    .o_motor_drive_secondary (o_motor_drive_secondary)
  );

  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_bvalid  = st_reg.bvalid;
  assign o_bresp   = st_reg.bresp;
  assign o_arready = rd_go;
  assign o_rvalid  = st_reg.rvalid;
  assign o_rresp   = st_reg.rresp;
  assign o_rdata   = st_reg.rdata;
  // pll held, speed info withheld in start 1
  assign o_pll_reset   = st_reg.mode == M_START1;
  assign o_speed_valid = st_reg.mode != M_START1;
  // fifo held at half in both jump modes
  assign o_fifo_reset_half = st_reg.mode == M_JUMP || st_reg.mode == M_JUMP1 ||
                             st_reg.play_init || st_reg.conceal;
  assign o_conceal     = st_reg.conceal;
  assign o_audio_mute  = st_reg.mode != M_PLAY;
  // data modes keep serial data in jump
  assign o_serial_mute = o_audio_mute &&
                         !(i_cdrom_mode && (st_reg.mode inside {M_JUMP, M_JUMP1}));
  assign o_spindle_halted_flag = st_reg.halted;
  assign o_irq = |(st_reg.irq_st & st_reg.irq_en);

  sequence s_play_pulse;
    o_fifo_reset_half ##1 (!o_fifo_reset_half || o_conceal);
  endsequence

  property p_start_drive;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode inside {M_START1, M_START2} |=> st_reg.drive == $signed($past(lim));
  endproperty
  a_start_drive: assert property (p_start_drive) else $error("start drive wrong");

  property p_stop_drive;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode inside {M_STOP1, M_STOP2} |=> st_reg.drive == -$signed($past(lim));
  endproperty
  a_stop_drive: assert property (p_stop_drive) else $error("brake drive wrong");

  property p_auto_jump;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode == M_START2 && i_speed_pct >= PCT_JUMP && !wr_mode
      |=> st_reg.mode == M_JUMP && st_reg.irq_st[IRQ_JUMP];
  endproperty
  a_auto_jump: assert property (p_auto_jump) else $error("no switch to jump");

  property p_stop_off;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode == M_STOP2 && i_speed_pct <= brk_pct && !wr_mode
      |=> st_reg.mode == M_OFF && o_spindle_halted_flag ##1 st_reg.drive == 0;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("no halt at brake level");

  property p_jump1_zero;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode == M_JUMP1 |=> st_reg.integ == 0;
  endproperty
  a_jump1_zero: assert property (p_jump1_zero) else $error("integrator not zero");

  property p_jump_hold;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode == M_JUMP |=> st_reg.integ == $past(st_reg.integ);
  endproperty
  a_jump_hold: assert property (p_jump_hold) else $error("integrator moved in jump");

  property p_awu_hold;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.awu && st_reg.sat && st_reg.mode == M_PLAY
      |=> st_reg.integ == $past(st_reg.integ);
  endproperty
  a_awu_hold: assert property (p_awu_hold) else $error("windup while clipped");

  property p_play_entry;
    @(posedge i_clk) disable iff (!rst_n)
      $rose(st_reg.mode == M_PLAY) |-> s_play_pulse;
  endproperty
  a_play_entry: assert property (p_play_entry) else $error("no fifo reset on play");

  property p_overflow;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode == M_PLAY && ovf_rise && !wr_mode
      |=> o_conceal && o_fifo_reset_half && st_reg.irq_st[IRQ_OVF];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not handled");

  property p_pll_start1;
    @(posedge i_clk) disable iff (!rst_n)
      st_reg.mode == M_START1 |-> o_pll_reset && !o_speed_valid && o_audio_mute;
  endproperty
  a_pll_start1: assert property (p_pll_start1) else $error("pll not reset");
endmodule

/* File: sim/spindle_motor_servo_modes_tb.sv */
// testbench for the spindle servo mode controller over its register bus
// assumes the bridge model takes speed from a set point and only counts the motor outputs
`timescale 1ns/100ps
module spindle_motor_servo_modes_tb import ssm_pkg::*; ;
  localparam int WIN = 4096;
  logic        clk = 0, resetn = 0, clr = 0, ovf = 0, cdrom = 0;
  logic [7:0]  awaddr = 0, araddr = 0, speed_set = 8'h32, fifo_err = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0]  wstrb = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid, pll_rst, spd_vld, fhalf;
  wire         conceal, amute, smute, halted, mpri, msec, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  speed;
  wire  [15:0] pri_cnt, sec_cnt, same_cnt;
  int          errors = 0, checked = 0, frh_cnt = 0, cnc_cnt = 0, b0, b1;

  ssm_servo_top dut_u (.i_clk(clk), .i_resetn(resetn), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_speed_pct(speed), .i_fifo_err(fifo_err), .i_fifo_overflow(ovf),
    .i_cdrom_mode(cdrom), .o_pll_reset(pll_rst), .o_speed_valid(spd_vld),
    .o_fifo_reset_half(fhalf), .o_conceal(conceal), .o_audio_mute(amute),
    .o_serial_mute(smute), .o_spindle_halted_flag(halted),
    .o_motor_drive_primary(mpri), .o_motor_drive_secondary(msec), .o_irq(irq));

  ssm_bridge_model part_u (.i_clk(clk), .i_clr(clr), .i_speed_set(speed_set),
    .i_motor_drive_primary(mpri), .i_motor_drive_secondary(msec),
    .o_speed_pct(speed), .o_pri_cnt(pri_cnt), .o_sec_cnt(sec_cnt),
    .o_same_cnt(same_cnt));

  always #12.5 clk = ~clk;

  // pulse counters for one-cycle outputs
  always @(posedge clk) begin
    if (fhalf === 1'b1) frh_cnt <= frh_cnt + 1;
    if (conceal === 1'b1) cnc_cnt <= cnc_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdt(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic meas(input logic [31:0] cfg, input logic [31:0] m);
    wr(A_OUTCFG, cfg);
    wr(A_MODE, m);
    cyc(4);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(WIN);
  endtask

  task automatic ovf_pulse();
    b0 = frh_cnt;
    b1 = cnc_cnt;
    ovf <= 1'b1;
    cyc(2);
    ovf <= 1'b0;
    cyc(8);
  endtask

  task automatic end_sim();
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 80000);
    errors++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    cyc(3);
    rdt(A_MODE);
    chk("mode_rst", rd, 32'h7);
    chk("mute_rst", amute, 1'b1);
    rdt(8'h20);
    chk("unm_rresp", resp, RESP_ERR);
    chk("unm_rdata", rd, 32'h0);
    wr(8'h24, 32'hFF);
    chk("unm_bresp", resp, RESP_ERR);
    for (int m = 0; m < 8; m++) begin
      wr(A_MODE, 32'(m));
      cyc(4);
      rdt(A_STATUS);
      chk("mode_st", rd[2:0], 32'(m));
      chk("pll_rst", pll_rst, m == 0);
      chk("spd_vld", spd_vld, m != 0);
      chk("amute", amute, m != 4);
      chk("fifo_half", fhalf, m == 2 || m == 3);
    end
    for (int k = 0; k < 4; k++) begin
      wr(A_OUTCFG, 32'(k));
      wr(A_MODE, 32'h0);
      cyc(4);
      rdt(A_DRIVE);
      chk("drv_start", rd, {24'h0, LIM_TBL[k]});
      wr(A_MODE, 32'h5);
      cyc(4);
      rdt(A_DRIVE);
      chk("drv_stop", rd, {24'h0, 8'(-LIM_TBL[k])});
    end
    meas(32'h0, 32'h7);
    chk("off_inv", same_cnt, 16'h0);
    chk("off_half", pri_cnt >= 1900 && pri_cnt <= 2200, 1'b1);
    meas(32'h0, 32'h0);
    chk("acc_dens", pri_cnt > 3072, 1'b1);
    meas(32'h4, 32'h0);
    chk("pwm_acc_sec", sec_cnt, 16'h0);
    chk("pwm_acc_pri", pri_cnt > 0, 1'b1);
    meas(32'h4, 32'h5);
    chk("pwm_brk_pri", pri_cnt, 16'h0);
    chk("pwm_brk_sec", sec_cnt > 0, 1'b1);
    wr(A_OUTCFG, 32'h0);
    wr(A_IRQ_CLR, 32'h7);
    wr(A_IRQ_EN, 32'h1);
    speed_set <= 8'h4A;
    wr(A_MODE, 32'h1);
    cyc(4);
    rdt(A_STATUS);
    chk("st2_hold", rd[2:0], 32'h1);
    chk("irq_idle", irq, 1'b0);
    speed_set <= PCT_JUMP;
    cyc(4);
    rdt(A_STATUS);
    chk("st2_jump", rd[2:0], 32'h2);
    chk("irq_jump", irq, 1'b1);
    wr(A_IRQ_CLR, 32'h1);
    cyc(2);
    chk("irq_clr", irq, 1'b0);
    speed_set <= 8'h0D;
    wr(A_MODE, 32'h6);
    cyc(4);
    chk("halt_no", halted, 1'b0);
    speed_set <= PCT_BRK12;
    cyc(4);
    rdt(A_STATUS);
    chk("halt12_st", rd[3:0], 32'hF);
    chk("halt_flag", halted, 1'b1);
    rdt(A_IRQ_ST);
    chk("irq_halt_st", rd, 32'h2);
    chk("irq_masked", irq, 1'b0);
    wr(A_OUTCFG, 32'h8);
    speed_set <= 8'h32;
    wr(A_MODE, 32'h6);
    cyc(2);
    chk("halt_wclr", halted, 1'b0);
    speed_set <= PCT_BRK12;
    cyc(4);
    rdt(A_STATUS);
    chk("brk6_hold", rd[2:0], 32'h6);
    speed_set <= PCT_BRK6;
    cyc(4);
    rdt(A_STATUS);
    chk("brk6_off", rd[3:0], 32'hF);
    wr(A_MODE, 32'h5);
    b0 = frh_cnt;
    wr(A_MODE, 32'h4);
    cyc(4);
    chk("play_half", 32'(frh_cnt - b0), 32'h1);
    chk("play_mute", amute, 1'b0);
    ovf_pulse();
    chk("ovf_conceal", 32'(cnc_cnt - b1), 32'h1);
    chk("ovf_half", 32'(frh_cnt - b0), 32'h1);
    rdt(A_IRQ_ST);
    chk("irq_ovf_st", rd[IRQ_OVF], 1'b1);
    wr(A_MODE, 32'h2);
    ovf_pulse();
    chk("jump_noconc", 32'(cnc_cnt - b1), 32'h0);
    cdrom <= 1'b1;
    cyc(2);
    chk("cd_smute", smute, 1'b0);
    chk("cd_amute", amute, 1'b1);
    wr(A_MODE, 32'h3);
    cyc(2);
    chk("cd_smute1", smute, 1'b0);
    cdrom <= 1'b0;
    cyc(2);
    chk("smute_back", smute, 1'b1);
    wr(A_LOOP, 32'h5D);
    rdt(A_LOOP);
    chk("loop_rb", rd, 32'h5D);
    wr(A_OUTCFG, 32'h3B);
    rdt(A_OUTCFG);
    chk("outcfg_rb", rd, 32'h3B);
    wr(A_MODE, 32'h0A);
    wr(A_MODE, 32'h04, 4'h0);
    rdt(A_MODE);
    chk("mode_awu", rd, 32'h0A);
    rdt(A_IRQ_CLR);
    chk("irqclr_rd", rd, 32'h0);
    // full error at top gain drives the loop into clipping with anti-windup on
    fifo_err <= 8'h7F;
    wr(A_LOOP, 32'h07);
    wr(A_MODE, 32'h0C);
    cyc(1200);
    rdt(A_STATUS);
    chk("awu_sat", rd, 32'h14);
    rdt(A_DRIVE);
    chk("sat_drive", rd, {24'h0, DRV_MAX});
    end_sim();
  end
endmodule

/* File: sim/ssm_bridge_model.sv */
// motor bridge model: reports disc speed and measures the drive duty
// assumes motor outputs are registered on i_clk; speed comes from a set point
`timescale 1ns/100ps
module ssm_bridge_model (
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  input  wire logic [7:0]  i_speed_set,
  input  wire logic        i_motor_drive_primary,
  input  wire logic        i_motor_drive_secondary,
  output logic      [7:0]  o_speed_pct,
  output logic      [15:0] o_pri_cnt,
  output logic      [15:0] o_sec_cnt,
  output logic      [15:0] o_same_cnt
);
  // speed reaches the controller one clock late, as from the pll
  always_ff @(posedge i_clk) begin
    o_speed_pct <= i_speed_set;
    if (i_clr) begin
      o_pri_cnt  <= '0;
      o_sec_cnt  <= '0;
      o_same_cnt <= '0;
    end else begin
      o_pri_cnt  <= o_pri_cnt + 16'(i_motor_drive_primary);
      o_sec_cnt  <= o_sec_cnt + 16'(i_motor_drive_secondary);
      o_same_cnt <= o_same_cnt + 16'(i_motor_drive_primary == i_motor_drive_secondary);
    end
  end
endmodule
